// ===== core/upc_pkg.sv
package upc_pkg;

  // ==========================================
  // pin counts and widths
  localparam int NUM_PINS  = 4;
  localparam int SYNC_BITS = 7;
  localparam int CS_IDX    = 4;
  localparam int SCLK_IDX  = 5;
  localparam int DIN_IDX   = 6;

  // ==========================================
  // register indices on the internal write port
  localparam logic [2:0] REG_PIN1_CFG = 3'h0;
  localparam logic [2:0] REG_PIN2_CFG = 3'h1;
  localparam logic [2:0] REG_PIN3_CFG = 3'h2;
  localparam logic [2:0] REG_PIN4_CFG = 3'h3;
  localparam logic [2:0] REG_PASS     = 3'h4;
  localparam logic [2:0] REG_SWITCH   = 3'h5;

  // ==========================================
  // reset values
  localparam logic [7:0] PIN_CFG_RST = 8'h08;
  localparam logic [7:0] PASS_RST    = 8'h00;
  localparam logic [7:0] SWITCH_RST  = 8'h00;

  // ==========================================
  // field positions
  localparam int PASS_PIN1_BIT = 4;
  localparam int SW_DAC_A      = 7;
  localparam int SW_DAC_B      = 6;
  localparam int SW_CO1_HI     = 5;
  localparam int SW_CO1_LO     = 4;
  localparam int SW_CO2_HI     = 3;
  localparam int SW_CO2_LO     = 2;

  // ==========================================
  // pin mode codes
  localparam logic [3:0] MODE_GP_IN    = 4'h0;
  localparam logic [3:0] MODE_GP_OUT   = 4'h1;
  localparam logic [3:0] MODE_DAC_A    = 4'h2;
  localparam logic [3:0] MODE_DAC_B    = 4'h3;
  localparam logic [3:0] MODE_CO_ONE   = 4'h4;
  localparam logic [3:0] MODE_CO_TWO   = 4'h5;
  localparam logic [3:0] MODE_SLEEP    = 4'h6;
  localparam logic [3:0] MODE_WAKE     = 4'h7;
  localparam logic [3:0] MODE_PWM      = 4'hB;
  localparam logic [3:0] MODE_SHUTDOWN = 4'hC;
  localparam logic [3:0] MODE_DAY_ALM  = 4'hD;
  localparam logic [3:0] MODE_CONV     = 4'hF;

  // pwm routing bit positions
  localparam int PWM_TO_DAC_A = 0;
  localparam int PWM_TO_DAC_B = 1;
  localparam int PWM_TO_CO1   = 2;
  localparam int PWM_TO_CO2   = 3;

  typedef struct packed {
    logic [3:0] pinModeSelect;
    logic       pullupEnable;
    logic       railSelect;
    logic       polarityHigh;
    logic       levelBit;
  } upc_pin_cfg_s;

  typedef struct packed {
    logic normallyOpenContact;
    logic normallyClosedContact;
  } upc_changeover_s;

endpackage : upc_pkg

// ===== core/user_pin_ctrl.sv
`timescale 1ns/1ns
// How it works
// RL1 - 4-bit mode per pin, resets to input
// RL2 - pullup only if bit set and input
// RL3 - rail select per pin, every mode
// RL4 - polarity bit sets assertion level
// RL5 - output drives level; readback shows pin
// RL6 - input mode flags rising and falling edges
// RL7 - modes 2..5 steer four switches
// RL8 - asserted sleep pin forces sleep
// RL9 - asserted edge on wake pin clears shutdown
// RL10 - software avoids reserved mode codes
// RL11 - pwm mode drives pwm, idles at polarity
// RL12 - shutdown mode mirrors shutdown flag
// RL13 - day alarm mode follows alarm flag
// RL14 - conversion done output ignores its mask
// RL15 - same-function pins are ORed
// RL16 - pass-through from cs rise to fall
// RL17 - edges and readback continue in pass-through
// RL18 - pin 4 carries inverted chip select
// RL19 - pin 3 carries sclk, pin 2 din
// RL20 - serial data out carries pin 1
// RL21 - dac switch ORs bit, pins, pwm
// RL22 - changeover control field, open when idle
// RL23 - high bit selects together or toggle
// RL24 - pin inputs synchronised before use
module user_pin_ctrl
  import upc_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic                          regWrite,
  input  wire logic [2:0]                    regIndex,
  input  wire logic [7:0]                    regWrData,
  input  wire logic [NUM_PINS-1:0]           pinIn,
  input  wire logic                          chipSelectN,
  input  wire logic                          serialClk,
  input  wire logic                          serialDataIn,
  input  wire logic                          pwmOut,
  input  wire logic                          pwmGeneratorEnable,
  input  wire logic [3:0]                    pwmRoute,
  input  wire logic                          shutdownFlag,
  input  wire logic                          alarmStatusFlag,
  input  wire logic                          convDoneStatus,
  input  wire logic [2*NUM_PINS-1:0]         flagClear,
  output logic [NUM_PINS-1:0][7:0]           pinCfgRead_ff,
  output logic [7:0]                         passRead_ff,
  output logic [7:0]                         switchRead_ff,
  output logic [NUM_PINS-1:0]                pinOut_ff,
  output logic [NUM_PINS-1:0]                pinOeN_ff,
  output logic [NUM_PINS-1:0]                pullupOn_ff,
  output logic [NUM_PINS-1:0]                railSelect_ff,
  output logic [NUM_PINS-1:0]                riseFlag_ff,
  output logic [NUM_PINS-1:0]                fallFlag_ff,
  output logic                               passActive_ff,
  output logic                               serialOutPass_ff,
  output logic                               serialOutPassEn_ff,
  output logic                               sleepForce_ff,
  output logic                               wakeClear_ff,
  output logic                               dacASwitch_ff,
  output logic                               dacBSwitch_ff,
  output upc_changeover_s                    changeoverOne_ff,
  output upc_changeover_s                    changeoverTwo_ff
);

  // ==========================================
  // registers
  upc_pin_cfg_s [NUM_PINS-1:0] pinCfg_ff;
  logic [7:0]                  passCtrl_ff;
  logic [7:0]                  switchCtrl_ff;
  logic                        lastWrPass_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinCfg_ff     <= {NUM_PINS{PIN_CFG_RST}}; // RL1 RL2 RL3 RL4
      passCtrl_ff   <= PASS_RST;
      switchCtrl_ff <= SWITCH_RST; // RL22
      lastWrPass_ff <= 1'b0;
    end else if (regWrite) begin
      if (regIndex <= REG_PIN4_CFG) begin
        pinCfg_ff[regIndex[1:0]] <= regWrData;
      end
      if (regIndex == REG_PASS) begin
        passCtrl_ff <= regWrData;
      end
      if (regIndex == REG_SWITCH) begin
        switchCtrl_ff <= regWrData;
      end
      lastWrPass_ff <= (regIndex == REG_PASS);
    end
  end

  // ==========================================
  // input synchronisers
  // three stages; a change counts once stages two and three agree
  logic [SYNC_BITS-1:0] rawIn;
  logic [SYNC_BITS-1:0] syncA_ff;
  logic [SYNC_BITS-1:0] syncB_ff;
  logic [SYNC_BITS-1:0] syncC_ff;
  logic [SYNC_BITS-1:0] filt_ff;
  logic [SYNC_BITS-1:0] nxt_filt;

  assign rawIn = {serialDataIn, serialClk, chipSelectN, pinIn};

  genvar g;
  generate
    for (g = 0; g < SYNC_BITS; g++) begin : gSync
      assign nxt_filt[g] = (syncB_ff[g] == syncC_ff[g]) ? syncC_ff[g] : filt_ff[g]; // RL24
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          syncA_ff[g] <= 1'b1;
          syncB_ff[g] <= 1'b1;
          syncC_ff[g] <= 1'b1;
          filt_ff[g]  <= 1'b1;
        end else begin
          syncA_ff[g] <= rawIn[g];
          syncB_ff[g] <= syncA_ff[g];
          syncC_ff[g] <= syncB_ff[g];
          filt_ff[g]  <= nxt_filt[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // pass-through window
  wire csHigh    = filt_ff[CS_IDX];
  wire csRise    = nxt_filt[CS_IDX] & ~filt_ff[CS_IDX];
  // cs low ends the window at once, even before the next write lands
  wire nxt_passActive = nxt_filt[CS_IDX] & (passActive_ff | (csRise & lastWrPass_ff)); // RL16

  // ==========================================
  // per-pin decode
  logic [NUM_PINS-1:0] lvl;
  logic [NUM_PINS-1:0] asserted;
  logic [NUM_PINS-1:0] isOut;
  logic [NUM_PINS-1:0] nxt_pinOut;
  logic [NUM_PINS-1:0] nxt_rise;
  logic [NUM_PINS-1:0] nxt_fall;
  logic [NUM_PINS-1:0] selDacA;
  logic [NUM_PINS-1:0] selDacB;
  logic [NUM_PINS-1:0] selCoOne;
  logic [NUM_PINS-1:0] selCoTwo;
  logic [NUM_PINS-1:0] selSleep;
  logic [NUM_PINS-1:0] wakeEdge;
  logic [NUM_PINS-1:0] passDrive;
  logic [NUM_PINS-1:0] passValue;

  // pass-through values: pin1 is input only, pin4 always driven when enabled
  assign passDrive = {passCtrl_ff[7], passCtrl_ff[6] & passActive_ff,
                      passCtrl_ff[5] & passActive_ff, 1'b0};
  assign passValue = {~passActive_ff, filt_ff[SCLK_IDX], filt_ff[DIN_IDX], 1'b0}; // RL18 RL19

  generate
    for (g = 0; g < NUM_PINS; g++) begin : gPin
      wire [3:0] md   = pinCfg_ff[g].pinModeSelect;
      wire       pol  = pinCfg_ff[g].polarityHigh;
      wire       rise = nxt_filt[g] & ~filt_ff[g];
      wire       fall = ~nxt_filt[g] & filt_ff[g];
      wire       edgeOn = (md == MODE_GP_IN) | (passDrive[g] & csHigh); // RL6 RL17
      wire       modeOut = (md == MODE_GP_OUT) | (md == MODE_PWM) | (md == MODE_SHUTDOWN)
                         | (md == MODE_DAY_ALM) | (md == MODE_CONV);
      // pwm disabled leaves pol, which is its idle level
      wire       pwmLvl  = pwmGeneratorEnable ? (pwmOut ~^ pol) : pol; // RL11
      logic      modeVal;

      assign lvl[g]      = filt_ff[g];
      assign asserted[g] = lvl[g] ~^ pol; // RL4
      assign isOut[g]    = modeOut | passDrive[g];
      always_comb begin
        case (md)
          MODE_GP_OUT:   modeVal = pinCfg_ff[g].levelBit; // RL5
          MODE_PWM:      modeVal = pwmLvl; // RL11
          MODE_SHUTDOWN: modeVal = shutdownFlag ~^ pol; // RL12
          MODE_DAY_ALM:  modeVal = alarmStatusFlag ~^ pol; // RL13
          MODE_CONV:     modeVal = convDoneStatus ~^ pol; // RL14
          default:       modeVal = 1'b0;
        endcase
      end
      assign nxt_pinOut[g] = passDrive[g] ? passValue[g] : modeVal;
      assign nxt_rise[g] = (edgeOn & rise) | (riseFlag_ff[g] & ~flagClear[NUM_PINS+g]);
      assign nxt_fall[g] = (edgeOn & fall) | (fallFlag_ff[g] & ~flagClear[g]);
      assign selDacA[g]  = (md == MODE_DAC_A) & asserted[g]; // RL7
      assign selDacB[g]  = (md == MODE_DAC_B) & asserted[g];
      assign selCoOne[g] = (md == MODE_CO_ONE) & asserted[g];
      assign selCoTwo[g] = (md == MODE_CO_TWO) & asserted[g];
      assign selSleep[g] = (md == MODE_SLEEP) & asserted[g];
      assign wakeEdge[g] = (md == MODE_WAKE) & (pol ? rise : fall); // RL9
    end
  endgenerate

  // ==========================================
  // switch control
  // unrouted pwm and unconfigured pins count as zero
  wire actDacA = switchCtrl_ff[SW_DAC_A] | (|selDacA)
               | (pwmRoute[PWM_TO_DAC_A] & pwmOut); // RL15 RL21
  wire actDacB = switchCtrl_ff[SW_DAC_B] | (|selDacB)
               | (pwmRoute[PWM_TO_DAC_B] & pwmOut); // RL21
  wire actCoOne = switchCtrl_ff[SW_CO1_LO] | (|selCoOne)
                | (pwmRoute[PWM_TO_CO1] & pwmOut); // RL22
  wire actCoTwo = switchCtrl_ff[SW_CO2_LO] | (|selCoTwo)
                | (pwmRoute[PWM_TO_CO2] & pwmOut); // RL22
  upc_changeover_s nxt_coOne;
  upc_changeover_s nxt_coTwo;

  assign nxt_coOne.normallyOpenContact   = actCoOne;
  assign nxt_coOne.normallyClosedContact =
    switchCtrl_ff[SW_CO1_HI] ? ~actCoOne : actCoOne; // RL23
  assign nxt_coTwo.normallyOpenContact   = actCoTwo;
  assign nxt_coTwo.normallyClosedContact =
    switchCtrl_ff[SW_CO2_HI] ? ~actCoTwo : actCoTwo; // RL23

  // ==========================================
  // readback: level bit shows the pin, not the stored bit
  logic [NUM_PINS-1:0][7:0] nxt_cfgRead;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : gRead
      assign nxt_cfgRead[g] = {pinCfg_ff[g][7:1], nxt_filt[g]}; // RL5 RL17
    end
  endgenerate

  // ==========================================
  // output flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinCfgRead_ff      <= '0;
      passRead_ff        <= PASS_RST;
      switchRead_ff      <= SWITCH_RST;
      pinOut_ff          <= '0;
      pinOeN_ff          <= '1;
      pullupOn_ff        <= '1;
      railSelect_ff      <= '0;
      riseFlag_ff        <= '0;
      fallFlag_ff        <= '0;
      passActive_ff      <= 1'b0;
      serialOutPass_ff   <= 1'b0;
      serialOutPassEn_ff <= 1'b0;
      sleepForce_ff      <= 1'b0;
      wakeClear_ff       <= 1'b0;
      dacASwitch_ff      <= 1'b0;
      dacBSwitch_ff      <= 1'b0;
      changeoverOne_ff   <= '0;
      changeoverTwo_ff   <= '0;
    end else begin
      pinCfgRead_ff      <= nxt_cfgRead;
      passRead_ff        <= passCtrl_ff;
      switchRead_ff      <= switchCtrl_ff;
      pinOut_ff          <= nxt_pinOut;
      pinOeN_ff          <= ~isOut;
      for (int i = 0; i < NUM_PINS; i++) begin
        pullupOn_ff[i]   <= pinCfg_ff[i].pullupEnable & ~isOut[i]; // RL2
        railSelect_ff[i] <= pinCfg_ff[i].railSelect; // RL3
      end
      riseFlag_ff        <= nxt_rise; // RL6
      fallFlag_ff        <= nxt_fall;
      passActive_ff      <= nxt_passActive; // RL16
      serialOutPass_ff   <= lvl[0]; // RL20
      serialOutPassEn_ff <= passCtrl_ff[PASS_PIN1_BIT] & passActive_ff; // RL20
      // clock buffers stay powered; only the sleep request is raised
      sleepForce_ff      <= (|selSleep) | shutdownFlag; // RL8 RL15
      wakeClear_ff       <= |wakeEdge; // RL9 RL15
      dacASwitch_ff      <= actDacA;
      dacBSwitch_ff      <= actDacB;
      changeoverOne_ff   <= nxt_coOne;
      changeoverTwo_ff   <= nxt_coTwo;
    end
  end

endmodule : user_pin_ctrl

// ===== verification/upc_monitor.sv
`timescale 1ns/1ns
module upc_monitor
  import upc_pkg::*;
(
  input wire logic                    clock,
  input wire logic                    sys_rst,
  input wire logic                    regWrite,
  input wire logic [2:0]              regIndex,
  input wire logic [7:0]              regWrData,
  input wire logic                    shutdownFlag,
  input wire logic [2*NUM_PINS-1:0]   flagClear,
  input wire logic [NUM_PINS-1:0]     pinOut_ff,
  input wire logic [NUM_PINS-1:0]     pinOeN_ff,
  input wire logic [NUM_PINS-1:0]     pullupOn_ff,
  input wire logic [NUM_PINS-1:0]     railSelect_ff,
  input wire logic [NUM_PINS-1:0]     riseFlag_ff,
  input wire logic [7:0]              passRead_ff,
  input wire logic [7:0]              switchRead_ff,
  input wire logic                    passActive_ff,
  input wire logic                    sleepForce_ff,
  input wire logic                    wakeClear_ff,
  input wire logic                    dacASwitch_ff,
  input upc_changeover_s              changeoverOne_ff
);
  // ==========================================
  // write sequences
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // a quiet cycle after the write keeps a later write from masking the effect
  sequence wr(ix, sel);
    regWrite && regIndex == ix && sel ##1 !regWrite;
  endsequence
  chk_gpo_drive: assert property (wr(REG_PIN1_CFG, regWrData[7:4] == MODE_GP_OUT) |=>
    !pinOeN_ff[0] && pinOut_ff[0] == $past(regWrData[0], 2)) else $error("gpo drive wrong");
  chk_rail_pick: assert property (wr(REG_PIN2_CFG, 1'b1) |=>
    railSelect_ff[1] == $past(regWrData[2], 2)) else $error("rail select wrong");
  chk_dac_bit: assert property (wr(REG_SWITCH, regWrData[SW_DAC_A]) |=> dacASwitch_ff)
    else $error("dac a switch open");
  chk_pullup_input: assert property ((pullupOn_ff & ~pinOeN_ff) == '0)
    else $error("pullup on driven pin");
  chk_flag_holds: assert property (riseFlag_ff[0] && !flagClear[4] |=> riseFlag_ff[0])
    else $error("rise flag lost");
  chk_pin4_low: assert property (passRead_ff[7] && passActive_ff |=>
    !pinOeN_ff[3] && !pinOut_ff[3]) else $error("pin4 not low");
  chk_contact_mode: assert property ($stable(switchRead_ff) |->
    (changeoverOne_ff.normallyOpenContact ^ changeoverOne_ff.normallyClosedContact)
    == switchRead_ff[SW_CO1_HI]) else $error("contact mode wrong");
  chk_sleep_follow: assert property (shutdownFlag [*2] |=> sleepForce_ff)
    else $error("sleep not forced");
  chk_wake_pulse: assert property (wakeClear_ff |=> !wakeClear_ff)
    else $error("wake pulse too long");
  chk_reset_out: assert property ($fell(sys_rst) |-> pinOeN_ff == 4'hF &&
    riseFlag_ff == 4'h0 && !passActive_ff) else $error("reset state wrong");
endmodule : upc_monitor

bind user_pin_ctrl upc_monitor mon_u (.clock, .sys_rst, .regWrite, .regIndex, .regWrData,
  .shutdownFlag, .flagClear, .pinOut_ff, .pinOeN_ff, .pullupOn_ff, .railSelect_ff,
  .riseFlag_ff, .passRead_ff, .switchRead_ff, .passActive_ff, .sleepForce_ff,
  .wakeClear_ff, .dacASwitch_ff, .changeoverOne_ff);

// ===== verification/upc_pin_model.sv
`timescale 1ns/1ns
module upc_pin_model
  import upc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic [NUM_PINS-1:0] pinOut_ff,
  input  wire logic [NUM_PINS-1:0] pinOeN_ff,
  input  wire logic [NUM_PINS-1:0] pullupOn_ff,
  input  wire logic [NUM_PINS-1:0] extEn,
  input  wire logic [NUM_PINS-1:0] extVal,
  output logic      [NUM_PINS-1:0] pinLevel
);
  logic [NUM_PINS-1:0] floatVal_ff = '0;
  // a floating line must not keep a clean last value
  always_ff @(posedge clock) begin
    floatVal_ff <= ~pinLevel;
  end
  assign pinLevel = (~pinOeN_ff & pinOut_ff)
                  | (pinOeN_ff & ((extEn & extVal) | (~extEn & (pullupOn_ff | floatVal_ff))));
endmodule : upc_pin_model

// ===== verification/tb.sv
`timescale 1ns/1ns
module tb;
  import upc_pkg::*;
  typedef struct packed { logic [2:0] ix; logic [7:0] d; logic [15:0] exp; } upc_row_s;
  logic clock, sys_rst, regWrite, chipSelectN, serialClk, serialDataIn, pwmOut;
  logic pwmGeneratorEnable, shutdownFlag, alarmStatusFlag, convDoneStatus;
  logic [2:0] regIndex;
  logic [7:0] regWrData, flagClear, passRead_ff, switchRead_ff;
  logic [3:0] pinIn, pwmRoute, extEn, extVal, pinOut_ff, pinOeN_ff, pullupOn_ff;
  logic [3:0] railSelect_ff, riseFlag_ff, fallFlag_ff;
  logic [3:0][7:0] pinCfgRead_ff;
  logic passActive_ff, serialOutPass_ff, serialOutPassEn_ff, sleepForce_ff, wakeClear_ff;
  logic dacASwitch_ff, dacBSwitch_ff;
  upc_changeover_s changeoverOne_ff, changeoverTwo_ff;
  int failures, compares, i;
  // expected {oeN, driven level, pullup, rail} after each write, state carried on
  // only defined mode codes are written; reserved ones stay unused
  upc_row_s rows [9] = '{'{3'h0, 8'h11, 16'hE1E0}, '{3'h1, 8'h14, 16'hC1C2},
    '{3'h2, 8'h0C, 16'hC1C6}, '{3'h3, 8'hB6, 16'h494E}, '{3'h3, 8'hB4, 16'h414E},
    '{3'h3, 8'hC4, 16'h494E}, '{3'h3, 8'hD6, 16'h414E}, '{3'h3, 8'hF4, 16'h494E},
    '{3'h1, 8'h10, 16'h494C}};

  user_pin_ctrl dut_u (.*);
  upc_pin_model pin_u (.clock, .pinOut_ff, .pinOeN_ff, .pullupOn_ff, .extEn, .extVal,
    .pinLevel(pinIn));

  // ==========================================
  // helpers
  task automatic wr(input logic [2:0] ix, input logic [7:0] d);
    @(posedge clock);
    regWrite  <= 1'b1;
    regIndex  <= ix;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========================================
  // main sequence
  initial begin
    {sys_rst, regWrite, regIndex, regWrData, flagClear, chipSelectN} = '0;
    {serialClk, serialDataIn, pwmOut, pwmGeneratorEnable, pwmRoute, shutdownFlag} = '0;
    {alarmStatusFlag, convDoneStatus, extEn, extVal, failures, compares} = '0;
    sys_rst = 1'b1;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(4);
    chk({pinCfgRead_ff[0], passRead_ff, switchRead_ff, pullupOn_ff}, 28'h090000F);
    foreach (rows[i]) begin
      wr(rows[i].ix, rows[i].d);
      cyc(3);
      chk({pinOeN_ff, pinOut_ff & ~pinOeN_ff, pullupOn_ff, railSelect_ff}, rows[i].exp);
    end
    // edge flags on a general input, then cleared
    wr(REG_PIN1_CFG, 8'h00);
    extEn <= 4'h1;
    extVal <= 4'h1;
    cyc(8);
    extVal[0] <= 1'b0;
    cyc(8);
    extVal[0] <= 1'b1;
    cyc(8);
    chk({riseFlag_ff[0], fallFlag_ff[0], pinCfgRead_ff[0][0]}, 3'b111);
    flagClear <= 8'h11;
    cyc(1);
    flagClear <= 8'h00;
    cyc(2);
    chk({riseFlag_ff[0], fallFlag_ff[0]}, 2'b00);
    // switch sources ORed: pins, pwm, register
    wr(REG_PIN3_CFG, 8'h22);
    wr(REG_PIN2_CFG, 8'h42);
    wr(REG_SWITCH, 8'h28);
    extEn <= 4'h7;
    extVal <= 4'h5;
    pwmRoute <= 4'h2;
    pwmOut <= 1'b1;
    cyc(8);
    chk({dacASwitch_ff, dacBSwitch_ff, changeoverOne_ff, changeoverTwo_ff}, 6'h35);
    wr(REG_PIN3_CFG, 8'h20);
    extVal <= 4'h7;
    pwmOut <= 1'b0;
    cyc(8);
    chk({dacASwitch_ff, dacBSwitch_ff, changeoverOne_ff, changeoverTwo_ff}, 6'h09);
    wr(REG_SWITCH, 8'h00);
    cyc(3);
    chk({dacASwitch_ff, changeoverOne_ff}, 3'b011);
    wr(REG_SWITCH, 8'h84);
    cyc(3);
    chk({dacASwitch_ff, changeoverTwo_ff}, 3'h7);
    // pass-through window held by chip select
    extEn <= 4'h1;
    wr(REG_PASS, 8'hF0);
    chipSelectN <= 1'b1;
    serialClk <= 1'b1;
    serialDataIn <= 1'b1;
    cyc(10);
    chk({passActive_ff, pinOeN_ff[3:1], pinOut_ff[3:1], serialOutPass_ff}, 8'h87);
    chk(serialOutPassEn_ff, 1'b1);
    chipSelectN <= 1'b0;
    cyc(8);
    chk({passActive_ff, pinOut_ff[3], pinOeN_ff[3]}, 3'b010);
    // status outputs at their assertion level, pin 4 back under its own mode
    wr(REG_PASS, 8'h00);
    convDoneStatus <= 1'b1;
    cyc(3);
    chk(pinOut_ff[3], 1'b0);
    wr(REG_PIN4_CFG, 8'hD6);
    alarmStatusFlag <= 1'b1;
    cyc(3);
    chk(pinOut_ff[3], 1'b1);
    wr(REG_PIN4_CFG, 8'hB6);
    pwmGeneratorEnable <= 1'b1;
    pwmOut <= 1'b1;
    cyc(3);
    chk(pinOut_ff[3], 1'b1);
    pwmOut <= 1'b0;
    cyc(3);
    chk(pinOut_ff[3], 1'b0);
    // wake edge then sleep level
    extVal[0] <= 1'b0;
    wr(REG_PIN1_CFG, 8'h72);
    cyc(8);
    extVal[0] <= 1'b1;
    compares++;
    for (i = 0; i < 16 && wakeClear_ff !== 1'b1; i++) cyc(1);
    if (wakeClear_ff !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t got %0h exp %0h", $time, wakeClear_ff, 1'b1);
      results();
    end
    wr(REG_PIN1_CFG, 8'h62);
    cyc(8);
    chk(sleepForce_ff, 1'b1);
    extVal[0] <= 1'b0;
    cyc(8);
    chk(sleepForce_ff, 1'b0);
    shutdownFlag <= 1'b1;
    cyc(8);
    chk(sleepForce_ff, 1'b1);
    results();
  end
endmodule : tb
